//--- shared/spio_pkg.sv
// Shared constants and types for the six- and eight-bit I/O ports
package spio_pkg;
    localparam int ADDR_W = 12;
    localparam int SIX_W = 5;
    localparam int EIGHT_W = 8;
    localparam int SYNC_W = 14;
    localparam logic [11:0] OFF_SIX_READ = 12'h000;
    localparam logic [11:0] OFF_SIX_LATCH = 12'h004;
    localparam logic [11:0] OFF_SIX_DIR = 12'h008;
    localparam logic [11:0] OFF_EIGHT_READ = 12'h00C;
    localparam logic [11:0] OFF_EIGHT_LATCH = 12'h010;
    localparam logic [11:0] OFF_EIGHT_DIR = 12'h014;
    localparam logic [11:0] OFF_CTRL = 12'h018;
    localparam int CTRL_MASTER_CLEAR_ENABLE_CFG_BIT = 0;
    localparam int CTRL_EXTERNAL_BUS_DISABLE_BIT = 1;
    localparam int CTRL_REMAP_BIT = 2;
    localparam int CTRL_DIGITAL_BIT = 3;
    localparam int INPUT_ONLY_BIT = 5;
    localparam logic [4:0] RST_SIX_DIR = 5'h1F;
    localparam logic [7:0] RST_EIGHT_DIR = 8'hFF;
    localparam logic [4:0] RST_SIX_LATCH = 5'h00;
    localparam logic [7:0] RST_EIGHT_LATCH = 8'h00;
    localparam logic [3:0] RST_CTRL = 4'h1;
    typedef enum logic [1:0] {
        SPIO_IDLE = 2'b01,
        SPIO_RESP = 2'b10
    } spio_apb_state_t;
endpackage : spio_pkg

//--- shared/spio_sync_if.sv
// Carrier between the port core and its input synchroniser
`timescale 1ns/10ps
interface spio_sync_if #(parameter int W = 14);
    logic [W-1:0] rawPins;
    logic [W-1:0] syncPins;
    modport core_side (output rawPins, input syncPins);
    modport sync_side (input rawPins, output syncPins);
endinterface : spio_sync_if

//--- design/spio_sync.sv
// Two-stage synchroniser for all port pin inputs
`timescale 1ns/10ps
module spio_sync #(
    parameter int W = 14
) (
    input wire logic clk,
    input wire logic reset_n,
    spio_sync_if.sync_side link
);
    logic [W-1:0] stageOne;
    logic [W-1:0] stageTwo;

    // First stage feeds only the second stage
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    stageOne[i] <= 1'b0;
                    stageTwo[i] <= 1'b0;
                end else begin
                    stageOne[i] <= link.rawPins[i];
                    stageTwo[i] <= stageOne[i];
                end
            end
        end
    endgenerate

    assign link.syncPins = stageTwo;
endmodule : spio_sync

//--- design/spio_top.sv
// Six-bit and eight-bit general-purpose I/O ports with APB registers
// Notes on behaviour
// - six-bit direction 1 tri-states, 0 drives latch
// - bits 0-4 bidirectional, bit 5 input only
// - latch register reads stored latch value
// - enabled peripheral may force pin direction
// - overrides never written into direction register
// - reset sets six-bit direction bits to ones
// - clear enable 1 makes bit 5 reset input
// - clear enable 0 makes bit 5 readable
// - unimplemented upper bits ignore writes, read zero
// - bits 1,2 shared with second serial port
// - bits 0,3,4 shared with capture/compare/PWM
// - eight-bit port bidirectional, direction as six-bit
// - eight-bit latch register reads stored latch
// - upper nibble analog or digital by config
// - reset puts upper nibble analog, reads zero
// - lower nibble carries address unless bus disabled
// - upper nibble carries PWM outputs when remapped
// - bus pins become I/O only when disable set
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/10ps
module spio_top #(
    parameter int SIX_W = spio_pkg::SIX_W,
    parameter int EIGHT_W = spio_pkg::EIGHT_W
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [5:0] sixPinIn,
    output logic [4:0] sixPinOut,
    output logic [4:0] sixPinOe,
    input wire logic [4:0] sixPeriphOutEn,
    input wire logic [4:0] sixPeriphInEn,
    input wire logic [4:0] sixPeriphOut,
    input wire logic [7:0] eightPinIn,
    output logic [7:0] eightPinOut,
    output logic [7:0] eightPinOe,
    input wire logic [7:0] eightPeriphOutEn,
    input wire logic [7:0] eightPeriphInEn,
    input wire logic [7:0] eightPeriphOut,
    input wire logic [3:0] upperAddressBits,
    input wire logic [3:0] pwmUpperOut,
    input wire logic [3:0] pwmUpperEn,
    output logic masterClearReq,
    output logic [3:0] analogInputsUpper
);
    spio_pkg::spio_apb_state_t apbState;
    spio_pkg::spio_apb_state_t next_apbState;
    logic [4:0] sixDirection;
    logic [4:0] sixLatch;
    logic [7:0] eightDirection;
    logic [7:0] eightLatch;
    logic [3:0] ctrl;
    logic [13:0] syncPins;
    logic [5:0] sixReadValue;
    logic [7:0] eightReadValue;
    logic [31:0] next_prdata;
    logic next_err;
    logic wrEn;
    logic [4:0] next_sixOut;
    logic [4:0] next_sixOe;
    logic [7:0] next_eightOut;
    logic [7:0] next_eightOe;
    logic masterClearEnable;
    logic busDisable;
    logic pwmRemap;
    logic upperDigital;

    spio_sync_if #(.W(spio_pkg::SYNC_W)) syncLink ();

    spio_sync #(.W(spio_pkg::SYNC_W)) u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .link(syncLink)
    );

    assign syncLink.rawPins = {eightPinIn, sixPinIn};
    assign syncPins = syncLink.syncPins;

    assign masterClearEnable = ctrl[spio_pkg::CTRL_MASTER_CLEAR_ENABLE_CFG_BIT];
    assign busDisable = ctrl[spio_pkg::CTRL_EXTERNAL_BUS_DISABLE_BIT];
    assign pwmRemap = ctrl[spio_pkg::CTRL_REMAP_BIT];
    assign upperDigital = ctrl[spio_pkg::CTRL_DIGITAL_BIT];

    // Pin driver choice: forced output, forced input, else software direction
    function automatic logic [1:0] pinDrive(
        input logic ovrOut,
        input logic ovrIn,
        input logic ovrVal,
        input logic dir,
        input logic lat
    );
        logic [1:0] res;
        res = {~dir, lat};
        if (ovrOut) begin
            res = {1'b1, ovrVal};
        end else if (ovrIn) begin
            res = {1'b0, lat};
        end
        return res;
    endfunction : pinDrive

    // Bit 5 reads only when it is not the clear input
    assign sixReadValue = {
        masterClearEnable ? 1'b0 : syncPins[spio_pkg::INPUT_ONLY_BIT],
        syncPins[4:0]
    };
    // Analog-mode pins read zero; conversions see the analog pad instead
    assign eightReadValue = {upperDigital ? syncPins[13:10] : 4'h0, syncPins[9:6]};

    // APB handshake: one wait state, answer registered
    always_comb begin
        next_apbState = apbState;
        case (apbState)
            spio_pkg::SPIO_IDLE: begin
                if (psel && penable) begin
                    next_apbState = spio_pkg::SPIO_RESP;
                end
            end
            spio_pkg::SPIO_RESP: begin
                next_apbState = spio_pkg::SPIO_IDLE;
            end
            default: begin
                next_apbState = spio_pkg::SPIO_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            apbState <= spio_pkg::SPIO_IDLE;
        end else begin
            apbState <= next_apbState;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pready <= 1'b0;
        end else begin
            pready <= (apbState == spio_pkg::SPIO_IDLE) && psel && penable;
        end
    end

    assign wrEn = psel && penable && pready && pwrite && !pslverr;

    // Read data and error decode
    always_comb begin
        next_prdata = 32'h0000_0000;
        next_err = 1'b0;
        if (paddr == spio_pkg::OFF_SIX_READ) begin
            next_prdata[5:0] = sixReadValue;
        end else if (paddr == spio_pkg::OFF_SIX_LATCH) begin
            next_prdata[4:0] = sixLatch;
        end else if (paddr == spio_pkg::OFF_SIX_DIR) begin
            next_prdata[4:0] = sixDirection;
        end else if (paddr == spio_pkg::OFF_EIGHT_READ) begin
            next_prdata[7:0] = eightReadValue;
        end else if (paddr == spio_pkg::OFF_EIGHT_LATCH) begin
            next_prdata[7:0] = eightLatch;
        end else if (paddr == spio_pkg::OFF_EIGHT_DIR) begin
            next_prdata[7:0] = eightDirection;
        end else if (paddr == spio_pkg::OFF_CTRL) begin
            next_prdata[3:0] = ctrl;
        end else begin
            next_err = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if ((apbState == spio_pkg::SPIO_IDLE) && psel && penable) begin
            prdata <= pwrite ? 32'h0000_0000 : next_prdata;
            pslverr <= next_err;
        end else if (!psel) begin
            pslverr <= 1'b0;
        end
    end

    // Six-bit port registers; upper bits never stored
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sixDirection <= spio_pkg::RST_SIX_DIR;
        end else if (wrEn && paddr == spio_pkg::OFF_SIX_DIR) begin
            sixDirection <= pwdata[4:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sixLatch <= spio_pkg::RST_SIX_LATCH;
        end else if (wrEn && (paddr == spio_pkg::OFF_SIX_LATCH || paddr == spio_pkg::OFF_SIX_READ)) begin
            sixLatch <= pwdata[4:0];
        end
    end

    // Eight-bit port registers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            eightDirection <= spio_pkg::RST_EIGHT_DIR;
        end else if (wrEn && paddr == spio_pkg::OFF_EIGHT_DIR) begin
            eightDirection <= pwdata[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            eightLatch <= spio_pkg::RST_EIGHT_LATCH;
        end else if (wrEn && (paddr == spio_pkg::OFF_EIGHT_LATCH || paddr == spio_pkg::OFF_EIGHT_READ)) begin
            eightLatch <= pwdata[7:0];
        end
    end

    // Control: clear enable, bus disable, remap, upper-nibble digital
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctrl <= spio_pkg::RST_CTRL;
        end else if (wrEn && paddr == spio_pkg::OFF_CTRL) begin
            ctrl <= pwdata[3:0];
        end
    end

    // Six-bit pin drivers; peripheral overrides stay out of the registers
    always_comb begin
        next_sixOut = 5'h00;
        next_sixOe = 5'h00;
        for (int i = 0; i < SIX_W; i++) begin
            {next_sixOe[i], next_sixOut[i]} = pinDrive(sixPeriphOutEn[i], sixPeriphInEn[i],
                sixPeriphOut[i], sixDirection[i], sixLatch[i]);
        end
    end

    // Eight-bit pin drivers with bus and PWM sharing
    always_comb begin
        next_eightOut = 8'h00;
        next_eightOe = 8'h00;
        for (int i = 0; i < EIGHT_W; i++) begin
            {next_eightOe[i], next_eightOut[i]} = pinDrive(eightPeriphOutEn[i], eightPeriphInEn[i],
                eightPeriphOut[i], eightDirection[i], eightLatch[i]);
        end
        for (int i = 0; i < 4; i++) begin
            if (pwmRemap && pwmUpperEn[i]) begin
                next_eightOe[i+4] = 1'b1;
                next_eightOut[i+4] = pwmUpperOut[i];
            end
        end
        // Bus owns the low nibble until explicitly disabled
        if (!busDisable) begin
            next_eightOe[3:0] = 4'hF;
            next_eightOut[3:0] = upperAddressBits;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sixPinOut <= 5'h00;
            sixPinOe <= 5'h00;
        end else begin
            sixPinOut <= next_sixOut;
            sixPinOe <= next_sixOe;
        end
    end

    // Reset value keeps the bus off the pins until ctrl is live
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            eightPinOut <= 8'h00;
            eightPinOe <= 8'h00;
        end else begin
            eightPinOut <= next_eightOut;
            eightPinOe <= next_eightOe;
        end
    end

    // Clear input is active low at the pin
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            masterClearReq <= 1'b0;
            analogInputsUpper <= 4'h0;
        end else begin
            masterClearReq <= masterClearEnable && !syncPins[spio_pkg::INPUT_ONLY_BIT];
            analogInputsUpper <= upperDigital ? 4'h0 : 4'hF;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    dir_reset_a: assert property ($rose(reset_n) |-> sixDirection == 5'h1F && eightDirection == 8'hFF)
        else $error("direction reset value wrong");
    six_drive_a: assert property (!(|sixPeriphOutEn) && !(|sixPeriphInEn) |=> sixPinOe == ~$past(sixDirection))
        else $error("six-bit enable not from direction");
    force_out_a: assert property (sixPeriphOutEn[0] |=> sixPinOe[0] && sixPinOut[0] == $past(sixPeriphOut[0]))
        else $error("peripheral override ignored");
    ovr_not_stored_a: assert property (!wrEn && $changed(sixPeriphOutEn) |=> $stable(sixDirection))
        else $error("override leaked into direction");
    latch_read_a: assert property (psel && penable && pready && !pwrite && paddr == spio_pkg::OFF_SIX_LATCH
        |-> prdata == {27'h0, sixLatch})
        else $error("latch read not latch value");
    upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("unimplemented bits not zero");
    port_write_a: assert property (wrEn && paddr == spio_pkg::OFF_SIX_READ |=> sixLatch == $past(pwdata[4:0]))
        else $error("port write missed latch");
    master_clear_input_a: assert property (masterClearEnable && !syncPins[5] |=> masterClearReq)
        else $error("clear request missing");
    input_only_a: assert property (psel && pready && !pwrite && paddr == spio_pkg::OFF_SIX_READ
        && masterClearEnable |-> !prdata[5])
        else $error("bit 5 visible in clear mode");
    analog_zero_a: assert property (psel && pready && !pwrite && paddr == spio_pkg::OFF_EIGHT_READ
        && !upperDigital |-> prdata[7:4] == 4'h0)
        else $error("analog pins not zero");
    bus_addr_a: assert property (!busDisable |=> eightPinOe[3:0] == 4'hF
        && eightPinOut[3:0] == $past(upperAddressBits))
        else $error("address bits not driven");
    sync_two_a: assert property ($past(reset_n, 3) |-> syncPins[4:0] == $past(sixPinIn[4:0], 2))
        else $error("synchroniser depth wrong");
    apb_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("slave answer late");
    // Bit 7 is never a bus pin, so only remap can steal it
    eight_drive_a: assert property (!eightPeriphOutEn[7] && !eightPeriphInEn[7] && !pwmRemap
        |=> eightPinOe[7] == !$past(eightDirection[7]))
        else $error("eight-bit enable not from direction");
    eight_latch_a: assert property (psel && penable && pready && !pwrite
        && paddr == spio_pkg::OFF_EIGHT_LATCH |-> prdata == {24'h0, eightLatch})
        else $error("eight-bit latch read wrong");
    analog_mode_a: assert property (!upperDigital |=> analogInputsUpper == 4'hF)
        else $error("analog mode not flagged");

    read_cov_c: cover property (psel && penable && pready && !pwrite);
    write_cov_c: cover property (wrEn ##1 psel && penable && pready && pwrite);
    bus_off_c: cover property ($rose(busDisable));
    remap_c: cover property (pwmRemap && |pwmUpperEn);
endmodule : spio_top

//--- tb/spio_pin_model.sv
// Board-side pin model for both ports
`timescale 1ns/10ps
module spio_pin_model (
    input wire logic [4:0] sixPinOut,
    input wire logic [4:0] sixPinOe,
    input wire logic [5:0] sixExt,
    input wire logic [7:0] eightPinOut,
    input wire logic [7:0] eightPinOe,
    input wire logic [7:0] eightExt,
    output logic [5:0] sixPinIn,
    output logic [7:0] eightPinIn
);
    // Released pins follow the outside source, never the last driven level
    assign sixPinIn = {sixExt[5], (sixPinOe & sixPinOut) | (~sixPinOe & sixExt[4:0])};
    assign eightPinIn = (eightPinOe & eightPinOut) | (~eightPinOe & eightExt);
endmodule : spio_pin_model

//--- tb/six_and_eight_bit_io_ports_tb_top.sv
// Self-checking bench for the six- and eight-bit I/O ports
`timescale 1ns/10ps
module six_and_eight_bit_io_ports_tb_top;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, masterClearReq;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic [5:0] sixPinIn, sixExt = '0;
    logic [4:0] sixPinOut, sixPinOe, sixPeriphOutEn = '0, sixPeriphInEn = '0, sixPeriphOut = '0;
    logic [7:0] eightPinIn, eightPinOut, eightPinOe, eightExt = '0;
    logic [7:0] eightPeriphOutEn = '0, eightPeriphInEn = '0, eightPeriphOut = '0;
    logic [3:0] upperAddressBits = '0, pwmUpperOut = '0, pwmUpperEn = '0, analogInputsUpper;
    int n_errors = 0, samples_checked = 0, mLat6, mDir6, mLat8, mDir8, mCtrl;
    logic [31:0] rd;
    logic er;

    always #50 clk = ~clk;

    spio_top u_dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sixPinIn(sixPinIn), .sixPinOut(sixPinOut), .sixPinOe(sixPinOe), .sixPeriphOutEn(sixPeriphOutEn),
        .sixPeriphInEn(sixPeriphInEn), .sixPeriphOut(sixPeriphOut), .eightPinIn(eightPinIn),
        .eightPinOut(eightPinOut), .eightPinOe(eightPinOe), .eightPeriphOutEn(eightPeriphOutEn),
        .eightPeriphInEn(eightPeriphInEn), .eightPeriphOut(eightPeriphOut),
        .upperAddressBits(upperAddressBits), .pwmUpperOut(pwmUpperOut), .pwmUpperEn(pwmUpperEn),
        .masterClearReq(masterClearReq), .analogInputsUpper(analogInputsUpper));

    spio_pin_model u_pins (.sixPinOut(sixPinOut), .sixPinOe(sixPinOe), .sixExt(sixExt),
        .eightPinOut(eightPinOut), .eightPinOe(eightPinOe), .eightExt(eightExt),
        .sixPinIn(sixPinIn), .eightPinIn(eightPinIn));

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] expv);
        samples_checked++;
        if (seen !== expv) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, expv, seen);
        end
    endtask : chk

    task automatic wrap_up();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up

    // Leading edge keeps a release and the next setup out of one time step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // Answer taken only at a rising edge that sees pready high
        while (pready !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 100) chk("pready", 32'(pready), 32'h1);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        chk("writeErr", 32'(e), 32'h0);
        case (a)
            spio_pkg::OFF_SIX_READ, spio_pkg::OFF_SIX_LATCH: mLat6 = d & 32'h1F;
            spio_pkg::OFF_SIX_DIR: mDir6 = d & 32'h1F;
            spio_pkg::OFF_EIGHT_READ, spio_pkg::OFF_EIGHT_LATCH: mLat8 = d & 32'hFF;
            spio_pkg::OFF_EIGHT_DIR: mDir8 = d & 32'hFF;
            default: mCtrl = d & 32'hF;
        endcase
    endtask : wr

    task automatic check_all();
        logic [4:0] eo6, ev6;
        logic [7:0] eo8, ev8, p8;
        logic [5:0] p6;
        logic [31:0] r, expv [7];
        logic e;
        for (int i = 0; i < 8; i++) begin
            if (i < 4 && !mCtrl[1]) begin
                eo8[i] = 1'b1;
                ev8[i] = upperAddressBits[i];
            end else if (i > 3 && mCtrl[2] && pwmUpperEn[i-4]) begin
                eo8[i] = 1'b1;
                ev8[i] = pwmUpperOut[i-4];
            end else begin
                eo8[i] = eightPeriphOutEn[i] | (~eightPeriphInEn[i] & ~mDir8[i]);
                ev8[i] = eightPeriphOutEn[i] ? eightPeriphOut[i] : mLat8[i];
            end
            if (i < 5) begin
                eo6[i] = sixPeriphOutEn[i] | (~sixPeriphInEn[i] & ~mDir6[i]);
                ev6[i] = sixPeriphOutEn[i] ? sixPeriphOut[i] : mLat6[i];
            end
        end
        p6 = {sixExt[5], (eo6 & ev6) | (~eo6 & sixExt[4:0])};
        p8 = (eo8 & ev8) | (~eo8 & eightExt);
        chk("sixPinOe", 32'(sixPinOe), 32'(eo6));
        chk("sixPinOut", 32'(sixPinOut & eo6), 32'(ev6 & eo6));
        chk("eightPinOe", 32'(eightPinOe), 32'(eo8));
        chk("eightPinOut", 32'(eightPinOut & eo8), 32'(ev8 & eo8));
        chk("masterClearReq", 32'(masterClearReq), 32'(mCtrl[0] & ~sixExt[5]));
        chk("analogInputsUpper", 32'(analogInputsUpper), mCtrl[3] ? 32'h0 : 32'hF);
        expv[0] = 32'({mCtrl[0] ? 1'b0 : p6[5], p6[4:0]});
        expv[1] = mLat6;
        expv[2] = mDir6;
        expv[3] = 32'({mCtrl[3] ? p8[7:4] : 4'h0, p8[3:0]});
        expv[4] = mLat8;
        expv[5] = mDir8;
        expv[6] = mCtrl;
        for (int k = 0; k < 7; k++) begin
            apb(1'b0, spio_pkg::OFF_SIX_READ + 12'(4 * k), 32'h0, r, e);
            chk("readData", r, expv[k]);
            chk("readErr", 32'(e), 32'h0);
        end
    endtask : check_all

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        wrap_up();
    end

    initial begin
        rd = $urandom(32'hEB1A);
        mLat6 = 0;
        mLat8 = 0;
        mDir6 = 32'h1F;
        mDir8 = 32'hFF;
        mCtrl = 1;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        check_all();
        apb(1'b1, 12'h020, 32'hFFFFFFFF, rd, er);
        chk("unmappedWriteErr", 32'(er), 32'h1);
        apb(1'b0, 12'h01C, 32'h0, rd, er);
        chk("unmappedReadErr", 32'(er), 32'h1);
        chk("unmappedReadData", rd, 32'h0);
        repeat (24) begin
            wr($urandom_range(1) ? spio_pkg::OFF_SIX_READ : spio_pkg::OFF_SIX_LATCH, $urandom);
            wr(spio_pkg::OFF_SIX_DIR, $urandom);
            wr($urandom_range(1) ? spio_pkg::OFF_EIGHT_READ : spio_pkg::OFF_EIGHT_LATCH, $urandom);
            wr(spio_pkg::OFF_EIGHT_DIR, $urandom);
            wr(spio_pkg::OFF_CTRL, $urandom);
            sixPeriphOutEn <= 5'($urandom);
            sixPeriphInEn <= 5'($urandom);
            sixPeriphOut <= 5'($urandom);
            // Upper overrides kept off under remap: that priority is left open
            eightPeriphOutEn <= mCtrl[2] ? {4'h0, 4'($urandom)} : 8'($urandom);
            eightPeriphInEn <= mCtrl[2] ? {4'h0, 4'($urandom)} : 8'($urandom);
            eightPeriphOut <= 8'($urandom);
            upperAddressBits <= 4'($urandom);
            pwmUpperOut <= 4'($urandom);
            pwmUpperEn <= 4'($urandom);
            sixExt <= 6'($urandom);
            eightExt <= 8'($urandom);
            repeat (6) @(posedge clk);
            check_all();
        end
        wrap_up();
    end
endmodule : six_and_eight_bit_io_ports_tb_top
